// *** core/dlm_core.sv ***
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module dlm_core #(
  parameter int ADDR_W = 48,
  parameter int CYC_W = 24,
  parameter int MS_TICK = dlm_pkg::MS_TICK_CYC,
  parameter int RESIGN_TMO = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mac_cycle_tick,
  input wire logic sched_beacon_seen,
  input wire logic nonpersist_tx_seen,
  input wire logic leader_seen_ind,
  input wire logic dflt_beacon_rx,
  input wire logic dflt_report_rx,
  input wire logic active_beacon_rx,
  input wire logic name_match,
  input wire logic [ADDR_W-1:0] rx_src_addr,
  input wire logic [15:0] rx_name_hash,
  input wire logic [2:0] rx_hash_key_select,
  input wire logic [15:0] calc_name_hash,
  input wire logic peer_preferred,
  input wire logic [7:0] peer_node_count,
  input wire logic [7:0] peer_profile,
  input wire logic peer_sc_capable,
  input wire logic resign_all_done,
  output logic handover_req_send,
  output logic fdb_report_send,
  output logic fab_report_send,
  output logic [dlm_pkg::REP_W-1:0] report_payload,
  output logic force_resign,
  output logic beacon_inhibit,
  output logic confirm_search,
  output logic register_req,
  output logic beacon_start,
  output logic [CYC_W-1:0] first_cycle_len,
  output logic hold_tx_clk,
  output logic skip_align,
  output logic [31:0] rank_params
);
  import dlm_pkg::*;

  // Parameter check at elaboration
  if (ADDR_W != 48 || CYC_W < 8 || CYC_W > 32 || MS_TICK < 1
      || RESIGN_TMO < 1) begin : g_param_check
    $error("dlm_core: unsupported parameters");
  end

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_reg;
  logic [31:0] own_rank_reg;
  logic [31:0] ldr_rank_reg;
  logic [31:0] own_lo_reg;
  logic [15:0] own_hi_reg;
  logic [31:0] ldr_lo_reg;
  logic [15:0] ldr_hi_reg;
  logic [31:0] prdata_reg;
  logic [CYC_W-1:0] last_len_reg;
  logic [2:0] fail_cnt_reg;
  dlm_state_t state_reg;
  dlm_state_t state_next;

  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite;
  wire hit_ctrl = paddr == OFF_CTRL;
  wire hit_orank = paddr == OFF_OWN_RANK;
  wire hit_lrank = paddr == OFF_LDR_RANK;
  wire hit_olo = paddr == OFF_OWN_ADDR_LO;
  wire hit_ohi = paddr == OFF_OWN_ADDR_HI;
  wire hit_llo = paddr == OFF_LDR_ADDR_LO;
  wire hit_lhi = paddr == OFF_LDR_ADDR_HI;
  wire hit_stat = paddr == OFF_STATUS;
  wire hit_cyc = paddr == OFF_CYCLE;
  wire mapped = hit_ctrl | hit_orank | hit_lrank | hit_olo | hit_ohi
              | hit_llo | hit_lhi | hit_stat | hit_cyc;
  wire sw_lead_set = wr & hit_ctrl & pwdata[CTRL_LEAD];
  wire sw_lead_clr = wr & hit_ctrl & ~pwdata[CTRL_LEAD];
  wire [31:0] status_word = {24'h000000, confirm_search, fail_cnt_reg,
                             1'b0, state_reg};
  wire [31:0] rd_mux =
      hit_ctrl ? {28'h0000000, ctrl_reg} :
      hit_orank ? own_rank_reg :
      hit_lrank ? ldr_rank_reg :
      hit_olo ? own_lo_reg :
      hit_ohi ? {16'h0000, own_hi_reg} :
      hit_llo ? ldr_lo_reg :
      hit_lhi ? {16'h0000, ldr_hi_reg} :
      hit_stat ? status_word :
      hit_cyc ? 32'(last_len_reg) : 32'h00000000;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= CTRL_RESET;
      own_rank_reg <= 32'h00000000;
      ldr_rank_reg <= 32'h00000000;
      own_lo_reg <= 32'h00000000;
      own_hi_reg <= 16'h0000;
      ldr_lo_reg <= 32'h00000000;
      ldr_hi_reg <= 16'h0000;
      prdata_reg <= 32'h00000000;
    end else begin
      if (setup) prdata_reg <= rd_mux;
      if (wr & hit_ctrl) ctrl_reg <= pwdata[CTRL_W-1:0];
      if (wr & hit_orank) own_rank_reg <= pwdata;
      if (wr & hit_lrank) ldr_rank_reg <= pwdata;
      if (wr & hit_olo) own_lo_reg <= pwdata;
      if (wr & hit_ohi) own_hi_reg <= pwdata[15:0];
      if (wr & hit_llo) ldr_lo_reg <= pwdata;
      if (wr & hit_lhi) ldr_hi_reg <= pwdata[15:0];
    end
  end

  // ---------------------------------------------------------------
  // Ranking
  // ---------------------------------------------------------------
  wire [ADDR_W-1:0] own_addr = {own_hi_reg, own_lo_reg};
  wire [ADDR_W-1:0] ldr_addr = {ldr_hi_reg, ldr_lo_reg};
  wire [RK_FW-1:0] o_prof = own_rank_reg[RK_PROF +: RK_FW];
  wire [RK_FW-1:0] l_prof = ldr_rank_reg[RK_PROF +: RK_FW];
  wire [RK_FW-1:0] o_vis = own_rank_reg[RK_VIS +: RK_FW];
  wire [RK_FW-1:0] l_vis = ldr_rank_reg[RK_VIS +: RK_FW];
  wire [RK_FW-1:0] o_tot = own_rank_reg[RK_TOT +: RK_FW];
  wire [RK_FW-1:0] l_tot = ldr_rank_reg[RK_TOT +: RK_FW];
  wire o_pref = own_rank_reg[RK_PREF];
  wire l_pref = ldr_rank_reg[RK_PREF];
  wire o_sc = own_rank_reg[RK_SC];
  wire l_sc = ldr_rank_reg[RK_SC];
  // Ratios compared by cross products
  wire [2*RK_FW-1:0] vis_o = (2*RK_FW)'(o_vis) * (2*RK_FW)'(l_tot);
  wire [2*RK_FW-1:0] vis_l = (2*RK_FW)'(l_vis) * (2*RK_FW)'(o_tot);
  wire own_gt_ldr = (o_pref != l_pref) ? o_pref :
                    (o_prof != l_prof) ? (o_prof > l_prof) :
                    (vis_o != vis_l) ? (vis_o > vis_l) :
                    (o_sc & ~l_sc);
  assign rank_params = own_rank_reg;

  logic [ADDR_W-1:0] own_rev;
  logic [ADDR_W-1:0] peer_rev;
  for (genvar gi = 0; gi < ADDR_W; gi++) begin : g_rev
    assign own_rev[gi] = own_addr[ADDR_W-1-gi];
    assign peer_rev[gi] = rx_src_addr[ADDR_W-1-gi];
  end
  wire merge_lose = (o_pref != peer_preferred) ? peer_preferred :
                    (o_tot != peer_node_count) ? (o_tot < peer_node_count) :
                    (o_prof != peer_profile) ? (o_prof < peer_profile) :
                    (o_sc != peer_sc_capable) ? peer_sc_capable :
                    (own_rev < peer_rev);

  // ---------------------------------------------------------------
  // Beacon events
  // ---------------------------------------------------------------
  wire is_node = state_reg == ST_NODE;
  wire is_leader = state_reg == ST_LEADER;
  wire fdb_evt = is_node & dflt_beacon_rx & name_match
               & (rx_src_addr != ldr_addr);
  wire merge_evt = is_leader & (((dflt_beacon_rx & name_match)
               & (rx_src_addr != own_addr)) | dflt_report_rx);
  wire hash_hit = active_beacon_rx & (rx_name_hash == calc_name_hash);
  wire fab_evt = is_node & hash_hit & (rx_src_addr != ldr_addr);
  wire conf_evt = is_leader & hash_hit & (rx_src_addr != own_addr);
  wire [REP_W-1:0] fab_payload = {5'h00, rx_hash_key_select, rx_name_hash,
                                  rx_src_addr};

  // ---------------------------------------------------------------
  // Failure detection and timers
  // ---------------------------------------------------------------
  logic quiet_reg;
  logic [CYC_W-1:0] cyc_cnt_reg;
  logic [15:0] lfsr_reg;
  logic [$clog2(MS_TICK+1)-1:0] ms_cnt_reg;
  logic [9:0] t1_cnt_reg;
  logic [$clog2(RESIGN_TMO+1)-1:0] rs_cnt_reg;
  wire activity = sched_beacon_seen | nonpersist_tx_seen
                | leader_seen_ind;
  wire [2:0] fail_thr = ctrl_reg[CTRL_BACKUP] ? FAIL_CYC_BACKUP
                                              : FAIL_CYC_NO_BACKUP;
  wire cyc_quiet = quiet_reg & ~activity;
  wire [2:0] fail_inc = (fail_cnt_reg == fail_thr) ? fail_cnt_reg
                                                   : fail_cnt_reg + 3'h1;
  wire fail_hit = mac_cycle_tick & cyc_quiet & (fail_inc == fail_thr);
  wire ms_tick = ms_cnt_reg == ($bits(ms_cnt_reg))'(MS_TICK - 1);
  wire [9:0] t1_max = 10'(T1_MAX_MS);
  wire [9:0] t1_seed = (lfsr_reg[9:0] > t1_max) ? t1_max
                                                : lfsr_reg[9:0];
  wire t1_done = t1_cnt_reg == 10'h000;
  wire rs_tmo = rs_cnt_reg == ($bits(rs_cnt_reg))'(RESIGN_TMO);
  wire lfsr_fb = lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10];

  always_ff @(posedge clk) begin
    if (srst) begin
      quiet_reg <= 1'b1;
      fail_cnt_reg <= 3'h0;
      cyc_cnt_reg <= '0;
      last_len_reg <= '0;
      lfsr_reg <= LFSR_SEED;
      ms_cnt_reg <= '0;
      t1_cnt_reg <= 10'h000;
      rs_cnt_reg <= '0;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_fb};
      ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + 1'b1;
      if (mac_cycle_tick) begin
        quiet_reg <= 1'b1;
        cyc_cnt_reg <= '0;
        fail_cnt_reg <= (cyc_quiet & is_node) ? fail_inc : 3'h0;
        if (~cyc_quiet) last_len_reg <= cyc_cnt_reg + 1'b1;
      end else begin
        if (activity) quiet_reg <= 1'b0;
        cyc_cnt_reg <= cyc_cnt_reg + 1'b1;
      end
      if (state_next == ST_WAIT_T1 && !(state_reg == ST_WAIT_T1)) begin
        t1_cnt_reg <= t1_seed;
      end else if (ms_tick && !t1_done) begin
        t1_cnt_reg <= t1_cnt_reg - 10'h001;
      end
      if (state_reg != ST_MERGE) rs_cnt_reg <= '0;
      else if (mac_cycle_tick && !rs_tmo) rs_cnt_reg <= rs_cnt_reg + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Role control
  // ---------------------------------------------------------------
  logic hreq_done_reg;
  logic took_over_reg;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_NODE: begin
        if (sw_lead_set) state_next = ST_LEADER;
        else if (fail_hit && ctrl_reg[CTRL_CAPABLE] && ctrl_reg[CTRL_WANT])
          state_next = ST_WAIT_T1;
      end
      ST_WAIT_T1: begin
        if (sched_beacon_seen) state_next = ST_NODE;
        else if (t1_done) state_next = ST_LEADER;
      end
      ST_LEADER: begin
        if (sw_lead_clr) state_next = ST_NODE;
        else if (merge_evt && merge_lose) state_next = ST_MERGE;
      end
      ST_MERGE: begin
        if (resign_all_done || rs_tmo) state_next = ST_RESIGNED;
      end
      ST_RESIGNED: begin
        if (sw_lead_clr || sched_beacon_seen) state_next = ST_NODE;
      end
      default: state_next = ST_NODE;
    endcase
  end

  wire takeover = state_reg == ST_WAIT_T1 && state_next == ST_LEADER;
  wire hreq_evt = is_node & ctrl_reg[CTRL_CAPABLE] & own_gt_ldr
                & ~hreq_done_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_NODE;
      hreq_done_reg <= 1'b0;
      took_over_reg <= 1'b0;
      handover_req_send <= 1'b0;
      fdb_report_send <= 1'b0;
      fab_report_send <= 1'b0;
      report_payload <= '0;
      force_resign <= 1'b0;
      confirm_search <= 1'b0;
      beacon_start <= 1'b0;
      first_cycle_len <= '0;
    end else begin
      state_reg <= state_next;
      hreq_done_reg <= own_gt_ldr & (hreq_done_reg | hreq_evt);
      handover_req_send <= hreq_evt;
      fdb_report_send <= fdb_evt;
      fab_report_send <= fab_evt;
      if (fab_evt) report_payload <= fab_payload;
      force_resign <= state_next == ST_MERGE && state_reg != ST_MERGE;
      beacon_start <= takeover;
      if (takeover) first_cycle_len <= last_len_reg;
      if (state_next == ST_WAIT_T1) took_over_reg <= 1'b1;
      else if (state_next != ST_LEADER) took_over_reg <= 1'b0;
      if (conf_evt) confirm_search <= 1'b1;
      else if (!is_leader || merge_evt) confirm_search <= 1'b0;
    end
  end

  assign beacon_inhibit = state_reg == ST_MERGE
                        || state_reg == ST_RESIGNED;
  assign register_req = state_reg == ST_RESIGNED;
  assign hold_tx_clk = took_over_reg;
  assign skip_align = took_over_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_handover_req: assert property (handover_req_send |->
    $past(own_gt_ldr) && $past(state_reg) == ST_NODE)
    else $error("handover request without higher rank");
  a_fdb_forward: assert property (fdb_evt |=> fdb_report_send)
    else $error("foreign default beacon not reported");
  a_merge_lose: assert property (merge_evt && merge_lose && !sw_lead_clr
    |=> state_reg == ST_MERGE ##1 beacon_inhibit)
    else $error("losing leader did not merge");
  a_merge_win: assert property (merge_evt && !merge_lose && !sw_lead_clr
    |=> state_reg == ST_LEADER && !force_resign)
    else $error("winning leader reacted to beacon");
  a_report_rsv: assert property (fab_report_send |->
    report_payload[REP_W-1:REP_RSV] == 5'h00)
    else $error("reserved report bits not zero");
  a_resign_force: assert property ($rose(state_reg == ST_MERGE) |->
    force_resign && beacon_inhibit)
    else $error("merge entered without resign");
  a_t1_range: assert property ($rose(state_reg == ST_WAIT_T1) |->
    t1_cnt_reg <= 10'(T1_MAX_MS))
    else $error("t1 out of range");
  a_t1_abort: assert property (state_reg == ST_WAIT_T1 && sched_beacon_seen
    |=> state_reg == ST_NODE && !beacon_start ##1 !beacon_start)
    else $error("takeover not aborted");
  a_first_len: assert property ($rose(beacon_start) |->
    first_cycle_len == $past(last_len_reg))
    else $error("first cycle length differs");
  a_takeover_start: assert property (beacon_start |->
    $past(state_reg) == ST_WAIT_T1 && state_reg == ST_LEADER)
    else $error("beacons started without takeover");
  a_active_report: assert property (fab_report_send |->
    $past(state_reg) == ST_NODE && $past(hash_hit))
    else $error("active report outside node role");
  a_fdb_node_only: assert property (fdb_report_send |->
    $past(state_reg) == ST_NODE && $past(name_match))
    else $error("default report outside node role");
endmodule // dlm_core
`default_nettype wire

// *** core/dlm_pkg.sv ***
package dlm_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OWN_RANK = 8'h04;
  localparam logic [7:0] OFF_LDR_RANK = 8'h08;
  localparam logic [7:0] OFF_OWN_ADDR_LO = 8'h0C;
  localparam logic [7:0] OFF_OWN_ADDR_HI = 8'h10;
  localparam logic [7:0] OFF_LDR_ADDR_LO = 8'h14;
  localparam logic [7:0] OFF_LDR_ADDR_HI = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_CYCLE = 8'h20;
  // CTRL bits
  localparam int CTRL_CAPABLE = 0;
  localparam int CTRL_LEAD = 1;
  localparam int CTRL_BACKUP = 2;
  localparam int CTRL_WANT = 3;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Rank word fields
  localparam int RK_PREF = 0;
  localparam int RK_SC = 1;
  localparam int RK_PROF = 8;
  localparam int RK_VIS = 16;
  localparam int RK_TOT = 24;
  localparam int RK_FW = 8;
  // Active report layout
  localparam int REP_ADDR = 0;
  localparam int REP_HASH = 48;
  localparam int REP_KEY = 64;
  localparam int REP_RSV = 67;
  localparam int REP_W = 72;
  // Timing
  localparam logic [2:0] FAIL_CYC_NO_BACKUP = 3'h3;
  localparam logic [2:0] FAIL_CYC_BACKUP = 3'h6;
  localparam int CLK_MHZ = 250;
  localparam int T1_MAX_MS = 1000;
  localparam int MS_NS = 1000000;
  localparam int MS_TICK_CYC = MS_NS / 1000 * CLK_MHZ;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  typedef enum logic [2:0] {
    ST_NODE, ST_WAIT_T1, ST_LEADER, ST_MERGE, ST_RESIGNED
  } dlm_state_t;
endpackage

// *** bench/dlm_peer_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// Peer nodes and current leader
// ---------------------------------------------------------------
module dlm_peer_model #(
  parameter int PERIOD = 40
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic busy,
  input wire logic abort,
  output logic mac_cycle_tick,
  output logic sched_beacon_seen,
  output logic nonpersist_tx_seen,
  output logic leader_seen_ind
);
  logic [7:0] cnt_reg;
  always_ff @(posedge clk) begin
    if (srst || mac_cycle_tick) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  // Fixed-length MAC cycles, activity only while leader alive or on abort
  assign mac_cycle_tick = (cnt_reg == 8'(PERIOD - 1));
  assign sched_beacon_seen = (busy && cnt_reg == 8'h01) || abort;
  assign nonpersist_tx_seen = busy && cnt_reg == 8'h05;
  assign leader_seen_ind = busy && cnt_reg == 8'h09;
endmodule // dlm_peer_model
`default_nettype wire

// *** bench/domain_leader_maintenance_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module domain_leader_maintenance_test;
  import dlm_pkg::*;
  localparam int P = 40;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, busy, abort;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rank_params, r;
  logic mac_cycle_tick, sched_beacon_seen, nonpersist_tx_seen, leader_seen_ind;
  logic dflt_beacon_rx, dflt_report_rx, active_beacon_rx, name_match, resign_all_done;
  logic [47:0] rx_src_addr;
  logic [15:0] rx_name_hash, calc_name_hash;
  logic [2:0] rx_hash_key_select;
  logic peer_preferred, peer_sc_capable, rd_err, x;
  logic [7:0] peer_node_count, peer_profile;
  logic handover_req_send, fdb_report_send, fab_report_send, force_resign, beacon_inhibit;
  logic confirm_search, register_req, beacon_start, hold_tx_clk, skip_align;
  logic [71:0] report_payload;
  logic [23:0] first_cycle_len;
  logic [31:0] rd;
  int mismatches, num_checks, n_hrq, n_fdb, n_fab, n_frs, n_bst, f, k;
  logic [31:0] c_own [6] = '{32'h09000200, 32'h03000201, 32'h05000700, 32'h05000200,
    32'h05000202, 32'h05000202};
  logic [17:0] c_peer [6] = '{18'h20404, 18'h20A04, 18'h00A05, 18'h00A05, 18'h00A05, 18'h00A05};
  logic [47:0] c_addr [6] = '{48'hA5, 48'hA5, 48'hA5, 48'hA5, 48'hF7, 48'hFF};

  dlm_core #(.MS_TICK(4), .RESIGN_TMO(2)) u_dlm_core (.clk, .srst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mac_cycle_tick,
    .sched_beacon_seen, .nonpersist_tx_seen, .leader_seen_ind, .dflt_beacon_rx,
    .dflt_report_rx, .active_beacon_rx, .name_match, .rx_src_addr, .rx_name_hash,
    .rx_hash_key_select, .calc_name_hash, .peer_preferred, .peer_node_count,
    .peer_profile, .peer_sc_capable, .resign_all_done, .handover_req_send,
    .fdb_report_send, .fab_report_send, .report_payload, .force_resign, .beacon_inhibit,
    .confirm_search, .register_req, .beacon_start, .first_cycle_len, .hold_tx_clk,
    .skip_align, .rank_params);
  dlm_peer_model #(.PERIOD(P)) u_dlm_peer_model (.clk, .srst, .busy, .abort,
    .mac_cycle_tick, .sched_beacon_seen, .nonpersist_tx_seen, .leader_seen_ind);

  // ---------------------------------------------------------------
  // Model and helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return v[0] ? ((v >> 1) ^ 32'hA3000000) : (v >> 1);
  endfunction
  function automatic logic loses(input logic [31:0] o, input logic [17:0] p,
    input logic [47:0] oa, input logic [47:0] pa);
    int ov[4];
    int pv[4];
    logic [47:0] ro;
    logic [47:0] rp;
    ov = '{int'(o[0]), int'(o[31:24]), int'(o[15:8]), int'(o[1])};
    pv = '{int'(p[17]), int'(p[16:9]), int'(p[8:1]), int'(p[0])};
    for (int j = 0; j < 4; j++) begin
      if (ov[j] != pv[j]) begin
        return ov[j] < pv[j];
      end
    end
    ro = {<<{oa}};
    rp = {<<{pa}};
    return ro < rp;
  endfunction
  always @(posedge clk) begin
    n_hrq += handover_req_send;
    n_fdb += fdb_report_send;
    n_fab += fab_report_send;
    n_frs += force_resign;
    n_bst += beacon_start;
  end
  task chk(input logic [71:0] seen, input logic [71:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) begin
      @(posedge clk);
    end
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task ev(input int kind);
    case (kind)
      0: dflt_beacon_rx <= 1'h1;
      1: dflt_report_rx <= 1'h1;
      2: active_beacon_rx <= 1'h1;
      default: resign_all_done <= 1'h1;
    endcase
    @(posedge clk);
    dflt_beacon_rx <= 1'h0;
    dflt_report_rx <= 1'h0;
    active_beacon_rx <= 1'h0;
    resign_all_done <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  task ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      while (mac_cycle_tick !== 1'h1) begin
        @(posedge clk);
      end
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog, sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    wrap_up;
  end
  initial begin
    {srst, busy, psel, penable, pwrite, abort} = 6'h30;
    {paddr, pwdata, r} = {8'h00, 32'h0, 32'd84083};
    {dflt_beacon_rx, dflt_report_rx, active_beacon_rx, name_match, resign_all_done} = 5'h0;
    {rx_src_addr, rx_name_hash, rx_hash_key_select, calc_name_hash} = 83'h0;
    {peer_preferred, peer_node_count, peer_profile, peer_sc_capable} = 18'h0;
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    apb(1'h0, OFF_CTRL, 32'h0);
    chk(rd[3:0], CTRL_RESET);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk(rd[2:0], 3'h0);
    apb(1'h0, 8'h24, 32'h0);
    chk({rd_err, rd}, 33'h100000000);
    apb(1'h1, OFF_CTRL, 32'h00000001);
    apb(1'h1, OFF_LDR_RANK, 32'h0A0A0300);
    apb(1'h1, OFF_OWN_RANK, 32'h0A0A0300);
    f = n_hrq;
    apb(1'h1, OFF_OWN_RANK, 32'h0A0A0400);
    repeat (3) @(posedge clk);
    chk(n_hrq - f, 1);
    chk(rank_params, 32'h0A0A0400);
    apb(1'h1, OFF_LDR_ADDR_LO, 32'h22223333);
    apb(1'h1, OFF_LDR_ADDR_HI, 32'h00001111);
    apb(1'h1, OFF_OWN_ADDR_LO, 32'hD086BBF7);
    apb(1'h1, OFF_OWN_ADDR_HI, 32'h000000B0);
    name_match <= 1'h1;
    rx_src_addr <= 48'h111122223333;
    f = n_fdb;
    ev(0);
    chk(n_fdb - f, 0);
    rx_src_addr <= {16'h0005, r};
    ev(0);
    chk(n_fdb - f, 1);
    for (int i = 0; i < 4; i++) begin
      r = lfsr(r);
      f = n_fab;
      rx_src_addr <= {r[15:0], r};
      rx_name_hash <= r[31:16];
      rx_hash_key_select <= r[2:0];
      calc_name_hash <= (i == 0) ? ~r[31:16] : r[31:16];
      ev(2);
      chk(n_fab - f, i != 0);
      if (i != 0) begin
        chk(report_payload, {5'h00, r[2:0], r[31:16], r[15:0], r});
      end
    end
    apb(1'h1, OFF_CTRL, 32'h0000000D);
    ticks(1);
    busy <= 1'h0;
    ticks(5);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk(rd[2:0], 3'h0);
    ticks(1);
    abort <= 1'h1;
    f = n_bst;
    @(posedge clk);
    abort <= 1'h0;
    busy <= 1'h1;
    apb(1'h0, OFF_STATUS, 32'h0);
    repeat (40) @(posedge clk);
    chk({rd[2:0], 32'(n_bst - f)}, 35'h0);
    apb(1'h1, OFF_CTRL, 32'h00000009);
    ticks(1);
    busy <= 1'h0;
    ticks(2);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk(rd[2:0], 3'h0);
    ticks(1);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk(rd[2:0] == 3'h1 || rd[2:0] == 3'h2, 1'h1);
    k = 0;
    while (n_bst == f && k < 4100) begin
      @(posedge clk);
      k++;
    end
    // Peer stays silent, so the waiting node takes over and starts beacons
    chk(n_bst - f, 1);
    chk(first_cycle_len, P);
    chk({hold_tx_clk, skip_align}, 2'h3);
    rx_src_addr <= 48'h00000000A5A5;
    ev(2);
    chk(confirm_search, 1'h1);
    for (int i = 0; i < 6; i++) begin
      apb(1'h1, OFF_CTRL, 32'h00000003);
      apb(1'h1, OFF_OWN_RANK, c_own[i]);
      {peer_preferred, peer_node_count, peer_profile, peer_sc_capable} <= c_peer[i];
      rx_src_addr <= c_addr[i];
      x = loses(c_own[i], c_peer[i], 48'h00B0D086BBF7, c_addr[i]);
      f = n_frs;
      ev(i % 2);
      apb(1'h0, OFF_STATUS, 32'h0);
      chk(rd[2:0], x ? 3'h3 : 3'h2);
      if (x) begin
        chk({32'(n_frs - f), beacon_inhibit}, 33'h3);
        ev(3);
        chk(register_req, 1'h1);
        apb(1'h1, OFF_CTRL, 32'h00000001);
      end
    end
    wrap_up;
  end
endmodule // domain_leader_maintenance_test
`default_nettype wire
